//--- core/clock_loss_detector.sv
/*
 Missing clock detector: watches a sampled copy of the system clock
 and fires when it stays at one level longer than the window.
 Assumes sys_clk_sample is synchronous to the faster ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_loss_detector
#(
	parameter int WINDOW_CYCLES = reset_source_pkg::MCD_WINDOW_CYCLES
)
(
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic ce,
	input  wire logic enable,
	input  wire logic sys_clk_sample,
	output logic      timeout
);
	logic        last_reg;
	logic [15:0] idle_reg;

	// Any edge of the watched clock restarts the one-shot
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			last_reg <= 1'b0;
			idle_reg <= 16'h0000;
		end
		else if (ce)
		begin
			last_reg <= sys_clk_sample;
			if (!enable || sys_clk_sample != last_reg)
				idle_reg <= 16'h0000;
			else if (idle_reg != 16'(WINDOW_CYCLES))
				idle_reg <= idle_reg + 16'h0001;
		end
	end

	assign timeout = enable && (idle_reg == 16'(WINDOW_CYCLES));
endmodule
`default_nettype wire

//--- core/reset_hold_timer.sv
/*
 Down-counter that stretches an internal reset to a minimum length.
 Assumes load and ce are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module reset_hold_timer
(
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic ce,
	input  wire logic load,
	output logic      done
);
	logic [7:0] count_reg;

	// Reload on each new cause so the hold always reaches full length
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			count_reg <= 8'(reset_source_pkg::HOLD_CYCLES);
		else if (ce)
		begin
			if (load)
				count_reg <= 8'(reset_source_pkg::HOLD_CYCLES);
			else if (count_reg != 8'h00)
				count_reg <= count_reg - 8'h01;
		end
	end

	assign done = (count_reg == 8'h00);
endmodule
`default_nettype wire

//--- core/reset_source_controller.sv
/*
 Reset source controller: gathers the reset sources, holds the system
 in reset, drives the reset pin for supply resets only, and records
 the cause in one 8-bit register that reads flags and writes enables.
 Assumes a single-cycle register port and synchronous source inputs;
 reset_n is the power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller
#(
	parameter int MCD_WINDOW_CYCLES = reset_source_pkg::MCD_WINDOW_CYCLES
)
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	input  wire logic        rst_pin_in,
	output logic             rst_pin_out,
	output logic             rst_pin_oe,
	input  wire logic        supply_mon_wr,
	input  wire logic        supply_mon_wdata,
	input  wire logic        supply_low,
	input  wire logic        supply_settled,
	input  wire logic        sleep_mode,
	input  wire logic        sys_clk_sample,
	input  wire logic        watchdog_overflow,
	input  wire logic        flash_fault,
	input  wire logic        rtc_alarm,
	input  wire logic        rtc_osc_fail,
	output logic             supply_monitor_on,
	output logic             sys_reset_n,
	output logic             defaults_load,
	output logic      [15:0] boot_addr
);
	reset_source_pkg::seq_state_e state_reg;
	logic [7:0] flags_reg;
	logic [7:0] pending_reg;
	logic [7:0] src;
	logic       supply_select_reg;
	logic       clock_loss_en_reg;
	logic       rtc_en_reg;
	logic       reg_write;
	logic       reg_read;
	logic       mcd_timeout;
	logic       hold_done;
	logic       hold_load;
	logic       release_now;

	// Register port decode
	assign reg_write = sfr_wr && (sfr_addr == reset_source_pkg::CAUSE_REG_ADDR);
	assign reg_read  = sfr_rd && (sfr_addr == reset_source_pkg::CAUSE_REG_ADDR);

	// Live reset requests, one per cause bit
	always_comb
	begin
		src = 8'h00;
		// Own drive on the pin is no outside request, else the hold never ends
		src[reset_source_pkg::BIT_PIN] = !rst_pin_in && !rst_pin_oe;
		// Supply fail is blocked in sleep to keep RAM alive
		src[reset_source_pkg::BIT_POWER] = (supply_select_reg && supply_monitor_on && supply_low && !sleep_mode)
			|| (reg_write && sfr_wdata[reset_source_pkg::BIT_POWER]
			&& (!supply_monitor_on || !supply_settled));
		src[reset_source_pkg::BIT_CLOCK_LOSS] = mcd_timeout;
		src[reset_source_pkg::BIT_WATCHDOG] = watchdog_overflow;
		src[reset_source_pkg::BIT_SOFT] = reg_write && sfr_wdata[reset_source_pkg::BIT_SOFT];
		src[reset_source_pkg::BIT_FLASH] = flash_fault;
		// Not gated by sleep so alarms still wake and reset
		src[reset_source_pkg::BIT_RTC] = rtc_en_reg && (rtc_alarm || rtc_osc_fail);
	end

	assign hold_load   = (src != 8'h00);
	assign release_now = (state_reg == reset_source_pkg::HOLD) && hold_done && (src == 8'h00);

	reset_hold_timer u_hold
	(
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.ce      (ce),
		.load    (hold_load),
		.done    (hold_done)
	);

	clock_loss_detector #(.WINDOW_CYCLES(MCD_WINDOW_CYCLES)) u_mcd
	(
		.ref_clk        (ref_clk),
		.reset_n        (reset_n),
		.ce             (ce),
		.enable         (clock_loss_en_reg && state_reg == reset_source_pkg::RUN),
		.sys_clk_sample (sys_clk_sample),
		.timeout        (mcd_timeout)
	);

	// Sequencer: run, hold while any cause persists, release one cycle
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			state_reg   <= reset_source_pkg::HOLD;
			pending_reg <= reset_source_pkg::CAUSE_POWER_VALUE;
		end
		else if (ce)
		begin
			case (state_reg)
				reset_source_pkg::RUN:
				begin
					if (src != 8'h00)
					begin
						state_reg   <= reset_source_pkg::HOLD;
						pending_reg <= src;
					end
				end
				reset_source_pkg::HOLD:
				begin
					pending_reg <= pending_reg | src;
					if (release_now)
						state_reg <= reset_source_pkg::RELEASE;
				end
				reset_source_pkg::RELEASE:
					state_reg <= reset_source_pkg::RUN;
				default:
					state_reg <= reset_source_pkg::HOLD;
			endcase
		end
	end

	// System reset asserted from the cycle after a cause is seen
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			sys_reset_n <= 1'b0;
		else if (ce)
			sys_reset_n <= (state_reg == reset_source_pkg::RELEASE)
				|| (state_reg == reset_source_pkg::RUN && src == 8'h00);
	end

	// Pin is pulled low only for power-on and supply resets
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			rst_pin_oe  <= 1'b1;
			rst_pin_out <= 1'b0;
		end
		else if (ce)
		begin
			if (state_reg == reset_source_pkg::RUN && src[reset_source_pkg::BIT_POWER])
				rst_pin_oe <= 1'b1;
			else if (state_reg == reset_source_pkg::HOLD && src[reset_source_pkg::BIT_POWER])
				rst_pin_oe <= 1'b1;
			else if (release_now)
				rst_pin_oe <= 1'b0;
		end
	end

	// Cause flags latched at release; power cause clears the rest
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			flags_reg <= reset_source_pkg::CAUSE_POWER_VALUE;
		else if (ce && release_now)
		begin
			if (pending_reg[reset_source_pkg::BIT_POWER])
				flags_reg <= reset_source_pkg::CAUSE_POWER_VALUE;
			else
				flags_reg <= pending_reg & reset_source_pkg::CAUSE_READ_MASK;
		end
	end

	// Supply monitor state survives all but power resets
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			supply_monitor_on <= 1'b1;
			supply_select_reg <= 1'b1;
		end
		else if (ce)
		begin
			if (release_now && pending_reg[reset_source_pkg::BIT_POWER])
			begin
				supply_monitor_on <= 1'b1;
				supply_select_reg <= 1'b1;
			end
			else if (state_reg == reset_source_pkg::RUN)
			begin
				if (supply_mon_wr)
					supply_monitor_on <= supply_mon_wdata;
				if (reg_write)
					supply_select_reg <= sfr_wdata[reset_source_pkg::BIT_POWER];
			end
		end
	end

	// Optional sources are write-only enables, dropped by any reset
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			clock_loss_en_reg <= 1'b0;
			rtc_en_reg        <= 1'b0;
		end
		else if (ce)
		begin
			if (state_reg != reset_source_pkg::RUN)
			begin
				clock_loss_en_reg <= 1'b0;
				rtc_en_reg        <= 1'b0;
			end
			else if (reg_write)
			begin
				clock_loss_en_reg <= sfr_wdata[reset_source_pkg::BIT_CLOCK_LOSS];
				rtc_en_reg        <= sfr_wdata[reset_source_pkg::BIT_RTC];
			end
		end
	end

	// Read side only ever sees the flags, never the enables
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			sfr_rdata <= 8'h00;
		else if (ce)
			sfr_rdata <= reg_read ? flags_reg : 8'h00;
	end

	// Restart defaults for the core at every release
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			defaults_load <= 1'b0;
			boot_addr     <= reset_source_pkg::BOOT_VECTOR;
		end
		else if (ce)
		begin
			defaults_load <= (state_reg == reset_source_pkg::RELEASE);
			boot_addr     <= reset_source_pkg::BOOT_VECTOR;
		end
	end

	AST_MONITOR_ON_AFTER_POR: assert property (@(posedge ref_clk)
		!reset_n |=> supply_monitor_on)
		else $error("supply monitor not on after power-on");

	AST_PIN_ENTERS_RESET: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ce && !rst_pin_in && state_reg == reset_source_pkg::RUN |=> !sys_reset_n && state_reg == reset_source_pkg::HOLD)
		else $error("low reset pin did not reset device");

	AST_PIN_UNDRIVEN: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state_reg == reset_source_pkg::HOLD && !pending_reg[reset_source_pkg::BIT_POWER] |-> !rst_pin_oe)
		else $error("reset pin driven for non-supply reset");

	AST_SOFT_FORCE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ce && reg_write && sfr_wdata[reset_source_pkg::BIT_SOFT] && state_reg == reset_source_pkg::RUN
		|=> !sys_reset_n && pending_reg[reset_source_pkg::BIT_SOFT])
		else $error("software write did not force reset");

	AST_POWER_CLEARS_OTHERS: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ce && release_now && pending_reg[reset_source_pkg::BIT_POWER]
		|=> flags_reg == reset_source_pkg::CAUSE_POWER_VALUE)
		else $error("flags wrong after power reset");

	AST_CAUSE_CAPTURED: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ce && release_now && !pending_reg[reset_source_pkg::BIT_POWER]
		|=> flags_reg == ($past(pending_reg) & reset_source_pkg::CAUSE_READ_MASK) && !flags_reg[1])
		else $error("cause flags not captured at release");

	AST_FLAGS_STEADY: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state_reg == reset_source_pkg::RUN && $past(state_reg) == reset_source_pkg::RUN |-> $stable(flags_reg))
		else $error("cause flags changed while running");

	AST_READ_FLAGS: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ce && reg_read |=> sfr_rdata == $past(flags_reg))
		else $error("register read does not return flags");

	AST_RESTART_DEFAULTS: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ce && state_reg == reset_source_pkg::RELEASE
		|=> defaults_load && sys_reset_n && boot_addr == reset_source_pkg::BOOT_VECTOR)
		else $error("restart defaults not loaded");

	AST_RTC_SLEEP: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ce && sleep_mode && rtc_en_reg && rtc_alarm && state_reg == reset_source_pkg::RUN |=> !sys_reset_n)
		else $error("RTC reset lost in sleep");
endmodule
`default_nettype wire

//--- core/reset_source_pkg.sv
/*
 Constants for the reset source controller: register address, bit
 positions, reset values and timing counts.
 Assumes a 100 MHz system clock on ref_clk.
*/
package reset_source_pkg;

	// Register address on the special register port
	localparam logic [7:0] CAUSE_REG_ADDR = 8'hEF;

	// Bit positions of the reset cause register
	localparam int BIT_PIN        = 0;
	localparam int BIT_POWER      = 1;
	localparam int BIT_CLOCK_LOSS = 2;
	localparam int BIT_WATCHDOG   = 3;
	localparam int BIT_SOFT       = 4;
	localparam int BIT_RESERVED   = 5;
	localparam int BIT_FLASH      = 6;
	localparam int BIT_RTC        = 7;

	// Flag values after power-on; reserved bit always reads zero
	localparam logic [7:0] CAUSE_POWER_VALUE = 8'h02;
	localparam logic [7:0] CAUSE_READ_MASK   = 8'hDF;

	// Core restarts here after every reset
	localparam logic [15:0] BOOT_VECTOR = 16'h0000;

	// Timing
	localparam int CLK_PERIOD_NS     = 10;
	localparam int HOLD_NS           = 1000;
	localparam int HOLD_CYCLES       = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MCD_WINDOW_NS     = 100000;
	localparam int MCD_WINDOW_CYCLES = MCD_WINDOW_NS / CLK_PERIOD_NS;

	// Reset sequencer states
	typedef enum logic [1:0] {RUN, HOLD, RELEASE} seq_state_e;

endpackage

//--- verif/rst_pin_model.sv
/*
 External reset circuitry on the open-drain reset pin, with pull-up.
 Assumes the bench commands when the outside world pulls the pin low.
*/
`timescale 1ns/1ps
`default_nettype none
module rst_pin_model
(
	input  wire logic pull_low,
	input  wire logic rst_pin_out,
	input  wire logic rst_pin_oe,
	output logic      pin_level
);
	// Wired-AND with pull-up; a released pin never keeps a stale low
	assign pin_level = (pull_low || (rst_pin_oe && !rst_pin_out)) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

//--- verif/tb_top.sv
/*
 Self-checking bench for the reset source controller.
 Assumes the clock-loss window shortened to 20 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {logic [7:0] en; logic [2:0] src; logic slp; logic [7:0] exp;} row_s;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  sfr_addr = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	wire  [7:0]  sfr_rdata;
	wire         rst_pin_in;
	wire         rst_pin_out;
	wire         rst_pin_oe;
	logic        mon_wr = 1'b0;
	logic        mon_wd = 1'b0;
	logic        sup_low = 1'b0;
	logic        sleep = 1'b0;
	logic        clk_smp = 1'b0;
	logic        clk_run = 1'b1;
	logic        wdt = 1'b0;
	logic        fl = 1'b0;
	logic        alarm = 1'b0;
	logic        osc = 1'b0;
	logic        settled = 1'b1;
	logic        pull = 1'b0;
	wire         mon_on;
	wire         sys_reset_n;
	wire         dl;
	wire  [15:0] boot;
	int          failures = 0;
	int          tests_run = 0;
	logic [7:0]  d;
	row_s        rows [8];

	always #5 ref_clk = ~ref_clk;
	// Watched clock toggles until a scenario stalls it
	always @(negedge ref_clk)
		if (clk_run)
			clk_smp <= ~clk_smp;

	rst_pin_model i_pin (.pull_low(pull), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .pin_level(rst_pin_in));

	reset_source_controller #(.MCD_WINDOW_CYCLES(20)) i_dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .ce(1'b1), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rst_pin_in(rst_pin_in),
		.rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .supply_mon_wr(mon_wr),
		.supply_mon_wdata(mon_wd), .supply_low(sup_low), .supply_settled(settled), .sleep_mode(sleep),
		.sys_clk_sample(clk_smp), .watchdog_overflow(wdt), .flash_fault(fl), .rtc_alarm(alarm),
		.rtc_osc_fail(osc), .supply_monitor_on(mon_on), .sys_reset_n(sys_reset_n),
		.defaults_load(dl), .boot_addr(boot));

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(negedge ref_clk);
		sfr_wr = 1'b0;
	endtask

	// Data stands one cycle after the read edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge ref_clk);
		sfr_rd = 1'b0;
		v = sfr_rdata;
	endtask

	task automatic wait_rst(input logic exp_oe);
		for (int i = 0; i < 60 && sys_reset_n !== 1'b0; i++)
			@(negedge ref_clk);
		check("sys_reset_n low", sys_reset_n, 1'b0);
		check("pin drive", rst_pin_oe, exp_oe);
		check("pin data", rst_pin_out, 1'b0);
	endtask

	// Hold of 100 cycles plus margin; first running cycle loads defaults
	task automatic wait_run;
		for (int i = 0; i < 300 && sys_reset_n !== 1'b1; i++)
			@(negedge ref_clk);
		check("sys_reset_n high", sys_reset_n, 1'b1);
		check("defaults pulse", dl, 1'b1);
		check("boot address", boot, 16'h0000);
	endtask

	task automatic quiet_check;
		repeat (40) @(negedge ref_clk);
		check("no reset", sys_reset_n, 1'b1);
	endtask

	// Supply monitor enable lives outside the register
	task automatic mon(input logic v);
		@(negedge ref_clk);
		mon_wd = v;
		mon_wr = 1'b1;
		@(negedge ref_clk);
		mon_wr = 1'b0;
	endtask

	initial
	begin
		#100000;
		failures++;
		tally_and_finish();
	end

	initial
	begin
		rows[0] = '{8'h00, 3'd0, 1'b0, 8'h01};
		rows[1] = '{8'h04, 3'd1, 1'b0, 8'h04};
		rows[2] = '{8'h00, 3'd2, 1'b0, 8'h08};
		rows[3] = '{8'h10, 3'd3, 1'b0, 8'h10};
		rows[4] = '{8'h00, 3'd4, 1'b0, 8'h40};
		rows[5] = '{8'h80, 3'd5, 1'b1, 8'h80};
		rows[6] = '{8'h80, 3'd6, 1'b0, 8'h80};
		rows[7] = '{8'h02, 3'd7, 1'b0, 8'h02};
		repeat (3) @(negedge ref_clk);
		check("pin drive in reset", rst_pin_oe, 1'b1);
		reset_n = 1'b1;
		check("monitor on", mon_on, 1'b1);
		wait_run();
		rd(8'hEF, d);
		check("power flags", d, 8'h02);
		// Each row: arm enables, raise one cause, read the recorded flag
		foreach (rows[k])
		begin
			if (rows[k].en != 8'h00)
				wr(8'hEF, rows[k].en);
			sleep = rows[k].slp;
			case (rows[k].src)
				3'd0: pull = 1'b1;
				3'd1: clk_run = 1'b0;
				3'd2: wdt = 1'b1;
				3'd4: fl = 1'b1;
				3'd5: alarm = 1'b1;
				3'd6: osc = 1'b1;
				3'd7: sup_low = 1'b1;
				default: ;
			endcase
			wait_rst(rows[k].src == 3'd7);
			{pull, wdt, fl, alarm, osc, sup_low, sleep} = 7'h00;
			clk_run = 1'b1;
			wait_run();
			rd(8'hEF, d);
			check("cause flags", d, rows[k].exp);
			rd(8'hEF, d);
			check("flags held", d, rows[k].exp);
		end
		// Selecting a switched-off monitor trips a power reset
		mon(1'b0);
		check("monitor off", mon_on, 1'b0);
		wr(8'hEF, 8'h02);
		wait_rst(1'b1);
		wait_run();
		rd(8'hEF, d);
		check("power flag again", d, 8'h02);
		check("monitor restored", mon_on, 1'b1);
		// Sources left disabled must not reset
		@(negedge ref_clk);
		alarm = 1'b1;
		@(negedge ref_clk);
		alarm = 1'b0;
		quiet_check();
		wr(8'hEF, 8'h04);
		wr(8'hEF, 8'h00);
		clk_run = 1'b0;
		quiet_check();
		clk_run = 1'b1;
		wr(8'hEE, 8'h10);
		wr(8'hEF, 8'h49);
		quiet_check();
		rd(8'hEE, d);
		check("other address", d, 8'h00);
		rd(8'hEF, d);
		check("flags unchanged", d, 8'h02);
		// Unsettled monitor selected trips a power reset
		settled = 1'b0;
		wr(8'hEF, 8'h02);
		wait_rst(1'b1);
		settled = 1'b1;
		wait_run();
		rd(8'hEF, d);
		check("unsettled flags", d, 8'h02);
		// Enable, wait for settling, then select: no reset
		mon(1'b0);
		settled = 1'b0;
		mon(1'b1);
		check("monitor back on", mon_on, 1'b1);
		repeat (3) @(negedge ref_clk);
		settled = 1'b1;
		wr(8'hEF, 8'h02);
		quiet_check();
		// Power-on reset again in mid-run
		reset_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		check("held in reset", sys_reset_n, 1'b0);
		check("pin driven in reset", rst_pin_oe, 1'b1);
		check("read data in reset", sfr_rdata, 8'h00);
		reset_n = 1'b1;
		wait_run();
		rd(8'hEF, d);
		check("flags after reset", d, 8'h02);
		tally_and_finish();
	end
endmodule
`default_nettype wire
